// ---- eim_params.svh ----
// Constants for the upper system event mask interrupt gate
`ifndef EIM_PARAMS_SVH
`define EIM_PARAMS_SVH

// Register indices; byte address is four times the index
`define EIM_MASK_IDX 6'h0e
`define EIM_STATUS_IDX 6'h0f

// Reset value of the event mask
`define EIM_MASK_RESET 32'h0000_0000

// Implemented mask bits: 11..18 and 20..29
`define EIM_VALID_BITS 32'h3ff7_f800

// Summary flag position in the status view
`define EIM_SUMMARY_BIT 0

// Event bit positions
`define EIM_BIT_PHY_HDR_DETECT 11
`define EIM_BIT_PHY_HDR_ERROR 12
`define EIM_BIT_FRAME_READY 13
`define EIM_BIT_FCS_GOOD 14
`define EIM_BIT_FCS_ERROR 15
`define EIM_BIT_RS_SYNC_LOSS 16
`define EIM_BIT_FRAME_WAIT_TIMEOUT 17
`define EIM_BIT_EDGE_DETECT_ERROR 18
`define EIM_BIT_RESERVED_19 19
`define EIM_BIT_RX_OVERRUN 20
`define EIM_BIT_PREAMBLE_TIMEOUT 21
`define EIM_BIT_PIN_EVENT 22
`define EIM_BIT_SLEEP_TO_INIT 23
`define EIM_BIT_RF_PLL_UNLOCK 24
`define EIM_BIT_CLK_PLL_UNLOCK 25
`define EIM_BIT_SFD_TIMEOUT 26
`define EIM_BIT_HALF_PERIOD_WARN 27
`define EIM_BIT_TX_BUFFER_ERROR 28
`define EIM_BIT_FILTER_REJECT 29
`define EIM_BIT_RESERVED_30 30
`define EIM_BIT_RESERVED_31 31

// Avalon response codes
`define EIM_RESP_OKAY 2'h0
`define EIM_RESP_DECODE_ERROR 2'h3

`endif

// ---- eim_pkg.sv ----
// Types for the upper system event mask interrupt gate
`default_nettype none
package eim_pkg;
  `include "eim_params.svh"

  typedef logic [31:0] eim_word_t;

  typedef enum logic [1:0] {
    EIM_RESP_OK = `EIM_RESP_OKAY,
    EIM_RESP_DECERR = `EIM_RESP_DECODE_ERROR
  } eim_resp_t;

  // Gray sequence along the access path
  typedef enum logic {
    EIM_BUS_IDLE = 1'b0,
    EIM_BUS_ACK = 1'b1
  } eim_bus_state_t;
endpackage : eim_pkg
`default_nettype wire

// ---- eim_gate.sv ----
// Upper system event mask register and interrupt line gating
`timescale 1ns/1ps
`default_nettype none
`include "eim_params.svh"

module eim_gate (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output eim_pkg::eim_word_t avs_readdata_out,
  output eim_pkg::eim_resp_t avs_response_out,
  output logic avs_waitrequest_out,
  // Latched event status from the status block
  input wire logic [31:0] evt_status_in,
  // Write-one clear pulses toward the status block
  output eim_pkg::eim_word_t status_clear_out,
  // Interrupt request and summary
  output logic irq_out,
  output logic interrupt_summary_flag_out
);
  import eim_pkg::*;

  eim_word_t system_event_mask;
  eim_word_t next_system_event_mask;
  eim_word_t next_readdata;
  eim_resp_t next_response;
  eim_word_t next_status_clear;
  eim_bus_state_t bus_state;
  eim_bus_state_t next_bus_state;
  logic next_waitrequest;
  eim_word_t gate;
  logic next_irq;

  function automatic logic sel_reg(input logic [7:0] addr, input logic [5:0] idx);
    sel_reg = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
  endfunction : sel_reg

  function automatic eim_word_t lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // Bus handshake: one cycle of waitrequest high, then one low
  logic req;
  logic done;
  logic hit_mask;
  logic hit_status;

  always_comb begin
    req = avs_read_in | avs_write_in;
    done = req && (bus_state == EIM_BUS_ACK);
    hit_mask = sel_reg(avs_address_in, `EIM_MASK_IDX);
    hit_status = sel_reg(avs_address_in, `EIM_STATUS_IDX);
    next_bus_state = bus_state;
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata_out;
    next_response = avs_response_out;
    unique case (bus_state)
      EIM_BUS_IDLE: begin
        if (req) begin
          next_bus_state = EIM_BUS_ACK;
          next_waitrequest = 1'b0;
          next_response = (hit_mask || hit_status) ? EIM_RESP_OK : EIM_RESP_DECERR;
          if (!avs_read_in) begin
            next_readdata = '0;
          end else if (hit_mask) begin
            next_readdata = system_event_mask;
          end else if (hit_status) begin
            next_readdata = (evt_status_in & `EIM_VALID_BITS)
              | ({31'h0, irq_out} << `EIM_SUMMARY_BIT);
          end else begin
            next_readdata = '0;
          end
        end
      end
      EIM_BUS_ACK: begin
        next_bus_state = EIM_BUS_IDLE;
      end
    endcase
  end

  // Mask register and clear pulses; reserved bits never store
  always_comb begin
    next_system_event_mask = system_event_mask;
    next_status_clear = '0;
    if (done && avs_write_in && hit_mask) begin
      next_system_event_mask = ((system_event_mask & ~lane_mask(avs_byteenable_in))
        | (avs_writedata_in & lane_mask(avs_byteenable_in)))
        & `EIM_VALID_BITS;
    end
    if (done && avs_write_in && hit_status) begin
      next_status_clear = avs_writedata_in & lane_mask(avs_byteenable_in)
        & `EIM_VALID_BITS;
    end
  end

  // Per-source gating; reserved positions stay zero
  always_comb begin
    gate = '0;
    gate[`EIM_BIT_PHY_HDR_DETECT] = system_event_mask[`EIM_BIT_PHY_HDR_DETECT]
      & evt_status_in[`EIM_BIT_PHY_HDR_DETECT];
    gate[`EIM_BIT_PHY_HDR_ERROR] = system_event_mask[`EIM_BIT_PHY_HDR_ERROR]
      & evt_status_in[`EIM_BIT_PHY_HDR_ERROR];
    gate[`EIM_BIT_FRAME_READY] = system_event_mask[`EIM_BIT_FRAME_READY]
      & evt_status_in[`EIM_BIT_FRAME_READY];
    gate[`EIM_BIT_FCS_GOOD] = system_event_mask[`EIM_BIT_FCS_GOOD]
      & evt_status_in[`EIM_BIT_FCS_GOOD];
    gate[`EIM_BIT_FCS_ERROR] = system_event_mask[`EIM_BIT_FCS_ERROR]
      & evt_status_in[`EIM_BIT_FCS_ERROR];
    gate[`EIM_BIT_RS_SYNC_LOSS] = system_event_mask[`EIM_BIT_RS_SYNC_LOSS]
      & evt_status_in[`EIM_BIT_RS_SYNC_LOSS];
    gate[`EIM_BIT_FRAME_WAIT_TIMEOUT] = system_event_mask[`EIM_BIT_FRAME_WAIT_TIMEOUT]
      & evt_status_in[`EIM_BIT_FRAME_WAIT_TIMEOUT];
    gate[`EIM_BIT_EDGE_DETECT_ERROR] = system_event_mask[`EIM_BIT_EDGE_DETECT_ERROR]
      & evt_status_in[`EIM_BIT_EDGE_DETECT_ERROR];
    gate[`EIM_BIT_RX_OVERRUN] = system_event_mask[`EIM_BIT_RX_OVERRUN]
      & evt_status_in[`EIM_BIT_RX_OVERRUN];
    gate[`EIM_BIT_PREAMBLE_TIMEOUT] = system_event_mask[`EIM_BIT_PREAMBLE_TIMEOUT]
      & evt_status_in[`EIM_BIT_PREAMBLE_TIMEOUT];
    gate[`EIM_BIT_PIN_EVENT] = system_event_mask[`EIM_BIT_PIN_EVENT]
      & evt_status_in[`EIM_BIT_PIN_EVENT];
    gate[`EIM_BIT_SLEEP_TO_INIT] = system_event_mask[`EIM_BIT_SLEEP_TO_INIT]
      & evt_status_in[`EIM_BIT_SLEEP_TO_INIT];
    gate[`EIM_BIT_RF_PLL_UNLOCK] = system_event_mask[`EIM_BIT_RF_PLL_UNLOCK]
      & evt_status_in[`EIM_BIT_RF_PLL_UNLOCK];
    gate[`EIM_BIT_CLK_PLL_UNLOCK] = system_event_mask[`EIM_BIT_CLK_PLL_UNLOCK]
      & evt_status_in[`EIM_BIT_CLK_PLL_UNLOCK];
    gate[`EIM_BIT_SFD_TIMEOUT] = system_event_mask[`EIM_BIT_SFD_TIMEOUT]
      & evt_status_in[`EIM_BIT_SFD_TIMEOUT];
    gate[`EIM_BIT_HALF_PERIOD_WARN] = system_event_mask[`EIM_BIT_HALF_PERIOD_WARN]
      & evt_status_in[`EIM_BIT_HALF_PERIOD_WARN];
    gate[`EIM_BIT_TX_BUFFER_ERROR] = system_event_mask[`EIM_BIT_TX_BUFFER_ERROR]
      & evt_status_in[`EIM_BIT_TX_BUFFER_ERROR];
    gate[`EIM_BIT_FILTER_REJECT] = system_event_mask[`EIM_BIT_FILTER_REJECT]
      & evt_status_in[`EIM_BIT_FILTER_REJECT];
    // Registered line lags status and mask by one cycle, but never glitches
    next_irq = |gate;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_state <= EIM_BUS_IDLE;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= '0;
      avs_response_out <= EIM_RESP_OK;
      system_event_mask <= `EIM_MASK_RESET;
      status_clear_out <= '0;
      irq_out <= 1'b0;
      interrupt_summary_flag_out <= 1'b0;
    end else begin
      bus_state <= next_bus_state;
      avs_waitrequest_out <= next_waitrequest;
      avs_readdata_out <= next_readdata;
      avs_response_out <= next_response;
      system_event_mask <= next_system_event_mask;
      status_clear_out <= next_status_clear;
      irq_out <= next_irq;
      interrupt_summary_flag_out <= next_irq;
    end
  end
endmodule : eim_gate
`default_nettype wire

// ---- eim_gate_props.sv ----
// Property checker for the event mask gate
`timescale 1ns/1ps
`default_nettype none
`include "eim_params.svh"
module eim_gate_props
  import eim_pkg::*;
(
  input wire logic clk_in, sys_rst_in, avs_read_in, avs_write_in,
  input wire logic [7:0] avs_address_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in, evt_status_in,
  input wire eim_word_t avs_readdata_out, status_clear_out,
  input wire eim_resp_t avs_response_out,
  input wire logic avs_waitrequest_out, irq_out, interrupt_summary_flag_out
);
  localparam logic [7:0] MA = {`EIM_MASK_IDX, 2'h0};
  localparam logic [7:0] SA = {`EIM_STATUS_IDX, 2'h0};
  // Shadow mask; full-word writes assumed
  logic [31:0] m, next_m;
  wire logic done = !avs_waitrequest_out;
  always_comb begin
    next_m = m;
    if (done && avs_write_in && avs_address_in == MA)
      next_m = avs_writedata_in & `EIM_VALID_BITS;
  end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) m <= 32'h0;
    else m <= next_m;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_irq; irq_out == |$past(m & evt_status_in & `EIM_VALID_BITS); endproperty
  property p_sum; interrupt_summary_flag_out == irq_out; endproperty
  property p_ans; $rose(avs_read_in || avs_write_in) |=> done; endproperty
  property p_one; done |=> !done; endproperty
  property p_dec; done && avs_address_in[1:0] != 2'h0 |-> avs_response_out == EIM_RESP_DECERR;
  endproperty
  property p_rdm; done && avs_read_in && avs_address_in == MA |-> avs_readdata_out == m;
  endproperty
  property p_clr; done && avs_write_in && avs_address_in == SA
    |=> status_clear_out == ($past(avs_writedata_in) & `EIM_VALID_BITS); endproperty
  property p_pulse; status_clear_out != 32'h0 |=> status_clear_out == 32'h0; endproperty
  a_irq: assert property (p_irq) else $error("irq does not follow mask and status");
  a_sum: assert property (p_sum) else $error("summary differs from irq");
  a_ans: assert property (p_ans) else $error("no answer one cycle after request");
  a_one: assert property (p_one) else $error("waitrequest low too long");
  a_dec: assert property (p_dec) else $error("misaligned access not refused");
  a_rdm: assert property (p_rdm) else $error("mask readback wrong");
  a_clr: assert property (p_clr) else $error("clear pulse wrong");
  a_pulse: assert property (p_pulse) else $error("clear pulse too long");
  c_irq: cover property ($rose(irq_out));
  c_dec: cover property (done && avs_response_out == EIM_RESP_DECERR);
  c_clr: cover property (status_clear_out != 32'h0);
endmodule : eim_gate_props
bind eim_gate eim_gate_props u_props (.*);
`default_nettype wire

// ---- eim_host.sv ----
// Host model counting interrupt requests
`timescale 1ns/1ps
`default_nettype none
module eim_host (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic irq_in,
  output logic [7:0] irq_count_out
);
  logic prev;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev <= 1'b0;
      irq_count_out <= 8'h0;
    end else begin
      prev <= irq_in;
      if (irq_in && !prev) irq_count_out <= irq_count_out + 8'h1;
    end
  end
endmodule : eim_host
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the event mask gate
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eim_pkg::*;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [7:0] avs_address_in = 8'h0, irq_count;
  logic [31:0] avs_writedata_in = 32'h0, evt_status_in = 32'h0, q;
  logic [1:0] r;
  eim_word_t avs_readdata_out, status_clear_out;
  eim_resp_t avs_response_out;
  logic avs_waitrequest_out, irq_out, interrupt_summary_flag_out;
  int mismatches = 0, n_compared = 0, cyc = 0;
  localparam logic [7:0] MA = 8'h38, SA = 8'h3c;
  localparam logic [31:0] VB = 32'h3ff7_f800;
  eim_gate dut (.avs_byteenable_in(4'hf), .*);
  eim_host u_host (.clk_in(clk_in), .rst_in(sys_rst_in), .irq_in(irq_out), .irq_count_out(irq_count));
  initial forever #25 clk_in = ~clk_in;
  task automatic print_verdict;
    $display("Compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low on a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    r = avs_response_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : bus
  task automatic settle;
    repeat (3) @(negedge clk_in);
  endtask : settle
  task automatic t_bits;
    for (int b = 11; b < 32; b++) begin
      bus(1'b1, MA, 32'h1 << b);
      evt_status_in <= 32'h1 << b;
      settle();
      chk({31'h0, irq_out}, {31'h0, VB[b]});
      @(posedge clk_in);
      evt_status_in <= ~(32'h1 << b);
      settle();
      chk({31'h0, irq_out}, 32'h0);
      bus(1'b0, MA, 32'h0);
      chk(q, VB & (32'h1 << b));
      evt_status_in <= 32'h0;
    end
  endtask : t_bits
  task automatic t_clear;
    logic [7:0] n0;
    n0 = irq_count;
    bus(1'b1, MA, 32'hffff_ffff);
    evt_status_in <= 32'h0000_2000;
    settle();
    bus(1'b0, SA, 32'h0);
    chk(q, 32'h0000_2001);
    bus(1'b1, MA, 32'h0);
    settle();
    chk({31'h0, irq_out}, 32'h0);
    bus(1'b1, MA, 32'hffff_ffff);
    settle();
    chk({31'h0, interrupt_summary_flag_out}, 32'h1);
    bus(1'b1, SA, 32'h0000_2000);
    evt_status_in <= 32'h0;
    @(negedge clk_in);
    chk(status_clear_out, 32'h0000_2000);
    settle();
    chk({31'h0, irq_out}, 32'h0);
    chk({24'h0, irq_count}, {24'h0, n0 + 8'h2});
  endtask : t_clear
  task automatic t_unmapped;
    bus(1'b0, 8'h40, 32'h0);
    chk({30'h0, r}, {30'h0, EIM_RESP_DECERR});
    chk(q, 32'h0);
    bus(1'b1, 8'h39, 32'h0);
    chk({30'h0, r}, {30'h0, EIM_RESP_DECERR});
    bus(1'b0, MA, 32'h0);
    chk(q, VB);
  endtask : t_unmapped
  initial begin
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    bus(1'b0, MA, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, irq_out}, 32'h0);
    t_bits();
    t_clear();
    t_unmapped();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
